// ---- common/utc_pkg.sv ----
// package for the uhf transmitter control block: states, constants, pin carriers
// assumes a single core clock that also stands for the crystal reference
package utc_pkg;

	// pll divider ratios chosen by band select and crystal
	localparam logic [6:0] UTC_RATIO_315 = 7'h20;
	localparam logic [6:0] UTC_RATIO_434 = 7'h34;
	localparam logic [6:0] UTC_RATIO_868 = 7'h40;

	// reference divided by this to form the data clock
	localparam int UTC_DCLK_DIV = 64;
	localparam int UTC_DCLK_HALF = UTC_DCLK_DIV / 2;
	localparam int UTC_DCLK_W = $clog2(UTC_DCLK_DIV);

	// lock-in time in ns, cycles derived at 10 ns per cycle (least time: round up)
	localparam int UTC_CLK_PERIOD_NS = 10;
	localparam int UTC_LOCK_IN_NS = 1000;
	localparam int UTC_LOCK_IN_CYC = (UTC_LOCK_IN_NS + UTC_CLK_PERIOD_NS - 1) / UTC_CLK_PERIOD_NS;

	// main state machine
	typedef enum logic [2:0] {
		UTC_STANDBY,
		UTC_ACQUIRE,
		UTC_WAIT_DATA,
		UTC_TRANSMIT,
		UTC_OUT_OF_LOCK,
		UTC_SHUTDOWN
	} utc_state_e;

	// microcontroller control pins
	typedef struct packed {
		logic enable;
		logic data;
		logic band_high;
		logic mode_fsk;
	} utc_ctrl_s;

	// analog status indications
	typedef struct packed {
		logic in_lock_range;
		logic out_of_lock;
		logic supply_low;
	} utc_stat_s;

	function automatic logic [6:0] utc_ratio(input logic band_high, input logic xtal_high);
		if (!band_high)
			return UTC_RATIO_868;
		return xtal_high ? UTC_RATIO_434 : UTC_RATIO_315;
	endfunction

endpackage

// ---- logic/utc_top.sv ----
// digital control of a pll tuned uhf transmitter
// assumes pins and analog status arrive asynchronously; core_clk is the crystal reference
//
// Notes on behaviour
// RULE_01 - band select picks pll divider ratio
// RULE_02 - phase detector out of limits kills rf
// RULE_03 - mode low: ook, data gates rf
// RULE_04 - mode high: fsk, data drives crystal switch
// RULE_05 - data 0 high carrier, 1 low
// RULE_06 - host sets band, mode before enable
// RULE_07 - data clock is reference divided by 64
// RULE_08 - standby keeps pll, rf, clock off
// RULE_09 - acquiring: rf off, data clock running
// RULE_10 - in range: wait, locked after lock-in time
// RULE_11 - data rising edge starts transmission
// RULE_12 - out of lock: rf off, clock runs
// RULE_13 - low supply latches off until enable low
// RULE_14 - data clock start and stop may be uneven
// RULE_15 - enable high leaves standby, low returns
// RULE_16 - analog indications are synchronised status inputs
`timescale 1ns/100ps

module utc_top
	import utc_pkg::*;
#(
	parameter logic xtal_high = 1'b1,
	parameter int lock_in_cyc = UTC_LOCK_IN_CYC
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire utc_ctrl_s ctrl_pins,
	input wire utc_stat_s analog_stat,
	output logic reference_data_clock_out,
	output logic rf_output_pin,
	output logic crystal_pull_switch,
	output logic pll_enable,
	output logic [6:0] pll_divider_ratio,
	output logic locked,
	output utc_state_e state_out
);

	localparam int LW = $clog2(lock_in_cyc + 1);

	typedef struct packed {
		utc_ctrl_s ctrl_s1;
		utc_ctrl_s ctrl_s2;
		utc_stat_s stat_s1;
		utc_stat_s stat_s2;
		logic data_prev;
		utc_state_e state;
		logic [UTC_DCLK_W-1:0] div_cnt;
		logic [LW-1:0] lock_cnt;
		logic dclk;
		logic rf;
		logic pull;
		logic pll_en;
		logic [6:0] ratio;
		logic locked;
	} utc_regs_s;

	utc_regs_s st_r;
	utc_regs_s st_nxt;

	// next-state logic for the whole block
	always_comb begin
		utc_ctrl_s c;
		utc_stat_s s;
		logic rise;
		logic clk_on;
		st_nxt = st_r;
		rise = 1'b0;
		clk_on = 1'b0;
		c = st_r.ctrl_s2;
		s = st_r.stat_s2;
		// two-stage synchronisers; only the second stage is read below
		st_nxt.ctrl_s1 = ctrl_pins;
		st_nxt.ctrl_s2 = st_r.ctrl_s1;
		st_nxt.stat_s1 = analog_stat; // RULE_16
		st_nxt.stat_s2 = st_r.stat_s1; // RULE_16
		st_nxt.data_prev = c.data;
		rise = c.data && !st_r.data_prev;

		// main state machine
		unique case (st_r.state)
			UTC_STANDBY: begin
				if (c.enable)
					st_nxt.state = UTC_ACQUIRE; // RULE_15
			end
			UTC_ACQUIRE: begin
				if (s.in_lock_range && !s.out_of_lock)
					st_nxt.state = UTC_WAIT_DATA; // RULE_10
			end
			UTC_WAIT_DATA: begin
				if (rise)
					st_nxt.state = UTC_TRANSMIT; // RULE_11
			end
			UTC_TRANSMIT: begin
			end
			UTC_OUT_OF_LOCK: begin
				// recover once the loop is back in range
				if (!s.out_of_lock && s.in_lock_range)
					st_nxt.state = UTC_WAIT_DATA;
			end
			UTC_SHUTDOWN: begin
			end
		endcase
		// loss of lock from any running state
		if (s.out_of_lock && (st_r.state == UTC_ACQUIRE || st_r.state == UTC_WAIT_DATA ||
				st_r.state == UTC_TRANSMIT))
			st_nxt.state = UTC_OUT_OF_LOCK; // RULE_02 RULE_12
		// low supply overrides every state but standby and latches; enable low below still wins
		if (s.supply_low && st_r.state != UTC_STANDBY)
			st_nxt.state = UTC_SHUTDOWN; // RULE_13
		// enable low exits every state and is the only exit from shutdown
		if (!c.enable)
			st_nxt.state = UTC_STANDBY; // RULE_13 RULE_15

		// lock-in timer runs while in range, cleared elsewhere
		if (st_nxt.state == UTC_WAIT_DATA || st_nxt.state == UTC_TRANSMIT) begin
			if (st_r.lock_cnt != LW'(lock_in_cyc))
				st_nxt.lock_cnt = st_r.lock_cnt + 1'b1;
		end else begin
			st_nxt.lock_cnt = '0;
		end
		st_nxt.locked = (st_nxt.lock_cnt == LW'(lock_in_cyc)); // RULE_10

		// pll and data clock run in every state but standby and shutdown
		clk_on = (st_nxt.state != UTC_STANDBY) && (st_nxt.state != UTC_SHUTDOWN); // RULE_08 RULE_09
		st_nxt.pll_en = clk_on; // RULE_08
		st_nxt.ratio = utc_ratio(c.band_high, xtal_high); // RULE_01

		// divide by 64; the count is already 1 in the first running cycle, so the first phase is 31 cycles
		if (clk_on) begin
			st_nxt.div_cnt = st_r.div_cnt + 1'b1; // RULE_07
			if (st_r.div_cnt == UTC_DCLK_W'(UTC_DCLK_HALF - 1) ||
					st_r.div_cnt == UTC_DCLK_W'(UTC_DCLK_DIV - 1))
				st_nxt.dclk = !st_r.dclk; // RULE_07
		end else begin
			// stops at once, the last period is cut short
			st_nxt.div_cnt = '0; // RULE_14
			st_nxt.dclk = 1'b0; // RULE_14
		end

		// modulation; band and mode are assumed steady while enabled
		st_nxt.rf = 1'b0; // RULE_02 RULE_09 RULE_12
		st_nxt.pull = 1'b0;
		if (st_nxt.state == UTC_TRANSMIT) begin
			if (c.mode_fsk) begin
				st_nxt.rf = 1'b1; // RULE_04
				st_nxt.pull = c.data; // RULE_04 RULE_05
			end else begin
				st_nxt.rf = c.data; // RULE_03
			end
		end
	end

	// single state register
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
			st_r.state <= UTC_STANDBY;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reference_data_clock_out = st_r.dclk;
	assign rf_output_pin = st_r.rf;
	assign crystal_pull_switch = st_r.pull;
	assign pll_enable = st_r.pll_en;
	assign pll_divider_ratio = st_r.ratio;
	assign locked = st_r.locked;
	assign state_out = st_r.state;

endmodule // utc_top

// ---- tb/utc_props.sv ----
// assertions on the utc_top pins
// assumes xtal_high at 1
`timescale 1ns/100ps
module utc_props
	import utc_pkg::*;
#(
	parameter int lock_in_cyc = UTC_LOCK_IN_CYC
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire utc_ctrl_s ctrl_pins,
	input wire logic reference_data_clock_out,
	input wire logic rf_output_pin,
	input wire logic crystal_pull_switch,
	input wire logic pll_enable,
	input wire logic [6:0] pll_divider_ratio,
	input wire logic locked,
	input wire utc_state_e state_out
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// data steady over the pin path, for any depth from 3 to 5 cycles
	sequence tx_steady;
		state_out == UTC_TRANSMIT && $past(state_out) == UTC_TRANSMIT
		&& $past(ctrl_pins.data, 3) == $past(ctrl_pins.data, 5)
		&& $past(ctrl_pins.data, 4) == $past(ctrl_pins.data, 3);
	endsequence
	chk_idle_off:
	assert property (state_out inside {UTC_STANDBY, UTC_SHUTDOWN}
		|-> !rf_output_pin && !pll_enable && !reference_data_clock_out) else $error("idle");
	chk_rf_held:
	assert property (state_out inside {UTC_ACQUIRE, UTC_OUT_OF_LOCK}
		|-> !rf_output_pin && pll_enable) else $error("rf held");
	chk_ook_follow:
	assert property (tx_steady ##0 !ctrl_pins.mode_fsk
		|-> rf_output_pin == $past(ctrl_pins.data, 4)) else $error("ook");
	chk_fsk_pull:
	assert property (tx_steady ##0 ctrl_pins.mode_fsk
		|-> rf_output_pin && crystal_pull_switch == $past(ctrl_pins.data, 4)) else $error("fsk");
	chk_band_ratio:
	assert property (pll_enable |-> pll_divider_ratio
		== (ctrl_pins.band_high ? UTC_RATIO_434 : UTC_RATIO_868)) else $error("ratio");
	chk_lock_wait:
	assert property ($past(state_out) == UTC_ACQUIRE && state_out == UTC_WAIT_DATA
		|-> !locked ##1 !locked) else $error("lock");
	chk_latch_hold:
	assert property (ctrl_pins.enable [*5] ##0 state_out == UTC_SHUTDOWN
		|=> state_out == UTC_SHUTDOWN) else $error("latch");
	chk_enable_drop:
	assert property (!ctrl_pins.enable [*5] |-> state_out == UTC_STANDBY) else $error("drop");
	cover property (state_out == UTC_TRANSMIT && ctrl_pins.mode_fsk);
	cover property (state_out == UTC_OUT_OF_LOCK);
	cover property (state_out == UTC_SHUTDOWN);
endmodule // utc_props

// ---- tb/utc_host.sv ----
// host model: drives control pins, counts data clock edges
// assumes pins change at the falling edge
`timescale 1ns/100ps
module utc_host
	import utc_pkg::*;
(
	input wire logic core_clk,
	input wire logic reference_data_clock_out,
	output utc_ctrl_s ctrl_pins,
	output int dclk_edges
);
	initial ctrl_pins = '0;
	initial dclk_edges = 0;
	// edges only, so an uneven first or last period is harmless
	always @(reference_data_clock_out) dclk_edges++;
	// caller gives band and mode before raising enable
	task automatic put(input logic en, d, b, m);
		@(negedge core_clk);
		ctrl_pins <= '{enable: en, data: d, band_high: b, mode_fsk: m};
	endtask
endmodule // utc_host

// ---- tb/utc_top_test.sv ----
// bench for utc_top: host model on pins, status driven here
// assumes lock_in_cyc cut to 4, xtal_high at 1
`timescale 1ns/100ps
module utc_top_test;
	import utc_pkg::*;
	logic core_clk = 0, resetn = 0, b, md, dclk, rf, pull, pen, lck;
	logic [6:0] ratio;
	utc_stat_s stat = '0;
	utc_ctrl_s pins;
	utc_state_e st;
	int edges, n0, fail_count = 0, total_checks = 0;
	// 100 MHz core clock
	always #5 core_clk = ~core_clk;
	utc_host utc_host_inst (.core_clk(core_clk), .reference_data_clock_out(dclk),
		.ctrl_pins(pins), .dclk_edges(edges));
	utc_top #(.lock_in_cyc(4)) utc_top_inst (.core_clk(core_clk), .resetn(resetn),
		.ctrl_pins(pins), .analog_stat(stat), .reference_data_clock_out(dclk),
		.rf_output_pin(rf), .crystal_pull_switch(pull), .pll_enable(pen),
		.pll_divider_ratio(ratio), .locked(lck), .state_out(st));
	task automatic chk(input string nm, input logic [6:0] e, g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic pin(input logic e, d);
		utc_host_inst.put(e, d, b, md);
	endtask
	task automatic go(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// watchdog, several times the expected run
	initial begin
		repeat (3000) @(posedge core_clk);
		fail_count++;
		final_report;
	end
	// two passes: high band with ook, then low band with fsk
	initial begin
		repeat (20) @(posedge core_clk);
		@(negedge core_clk) resetn = 1;
		for (int m = 0; m < 2; m++) begin
			b = !m[0];
			md = m[0];
			pin(0, 0);
			pin(1, 0);
			go(40);
			chk("state", UTC_ACQUIRE, st);
			chk("rf", 0, rf);
			chk("ratio", b ? UTC_RATIO_434 : UTC_RATIO_868, ratio);
			n0 = edges;
			go(128);
			chk("dclk", 4, 7'(edges - n0));
			stat.in_lock_range = 1;
			go(5);
			chk("state", UTC_WAIT_DATA, st);
			go(6);
			chk("locked", 1, lck);
			pin(1, 1);
			go(6);
			chk("state", UTC_TRANSMIT, st);
			chk("rf", 1, rf);
			chk("pull", md, pull);
			pin(1, 0);
			go(6);
			chk("rf", md, rf);
			chk("pull", 0, pull);
			stat.out_of_lock = 1;
			go(6);
			chk("state", UTC_OUT_OF_LOCK, st);
			chk("rf", 0, rf);
			// clock keeps running while the loop is out of lock
			n0 = edges;
			go(64);
			chk("dclk", 2, 7'(edges - n0));
			// loop back in range returns to waiting
			stat.out_of_lock = 0;
			go(6);
			chk("state", UTC_WAIT_DATA, st);
			stat.supply_low = 1;
			go(6);
			stat = '0;
			go(6);
			chk("state", UTC_SHUTDOWN, st);
			pin(0, 0);
			go(6);
			chk("state", UTC_STANDBY, st);
			chk("pll", 0, pen);
			$display("pass %0d done", m);
		end
		final_report;
	end
endmodule // utc_top_test
bind utc_top utc_props #(.lock_in_cyc(lock_in_cyc)) utc_props_inst (.core_clk(core_clk),
	.resetn(resetn), .ctrl_pins(ctrl_pins), .reference_data_clock_out(reference_data_clock_out),
	.rf_output_pin(rf_output_pin), .crystal_pull_switch(crystal_pull_switch),
	.pll_enable(pll_enable), .pll_divider_ratio(pll_divider_ratio), .locked(locked),
	.state_out(state_out));
